// *** hw/msd_pkg.sv ***
// Shared constants and carriers for the memory select and serial port decode block.
package msd_pkg;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 8;
  localparam int unsigned SEG_COUNT = 12;
  localparam int unsigned SEG_IDX_W = 4;
  localparam int unsigned ATTR_COUNT = 3;
  localparam int unsigned ECS_W = 3;

  localparam logic [REG_AW-1:0] SERIAL_CFG_OFS = 8'h4E;
  localparam logic [REG_AW-1:0] MEMSEL_CTRL_OFS = 8'h4F;
  localparam logic [REG_AW-1:0] ROM_C_ATTR_OFS = 8'h54;
  localparam logic [REG_AW-1:0] ROM_D_ATTR_OFS = 8'h55;
  localparam logic [REG_AW-1:0] BIOS_E_ATTR_OFS = 8'h56;

  localparam logic [REG_DW-1:0] ATTR_RESET = 8'h00;
  localparam logic MEMSEL_EN_RESET = 1'h0;
  localparam int unsigned MEMSEL_EN_BIT = 4;
  localparam int unsigned COM_A_LSB = 0;
  localparam int unsigned COM_B_LSB = 2;

  // Memory window 0C0000h to 0EFFFFh: top bits zero, bits 19:18 set, 17:16 not both set.
  localparam logic [11:0] SEG_TOP_ZERO = 12'h000;
  localparam logic [1:0] SEG_BAND = 2'h3;
  localparam logic [1:0] SEG_EXCLUDED = 2'h3;

  // Serial ranges compared on I/O address bits 15:3.
  localparam logic [12:0] COM_PRIMARY_BASE = 13'h007F;
  localparam logic [12:0] COM_SECONDARY_BASE = 13'h005F;

  // Encoded select codes; the values are arbitrary.
  localparam logic [ECS_W-1:0] ECS_IDLE = 3'h7;
  localparam logic [ECS_W-1:0] ECS_PORT_A = 3'h2;
  localparam logic [ECS_W-1:0] ECS_PORT_B = 3'h3;

  typedef enum logic [1:0] {
    MSD_COM_PRIMARY = 2'h0,
    MSD_COM_SECONDARY = 2'h1,
    MSD_COM_RSVD = 2'h2,
    MSD_COM_OFF = 2'h3
  } msd_com_sel_e;

  typedef struct packed {
    logic        valid;
    logic        io;
    logic        write;
    logic [31:0] addr;
  } msd_access_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
  } msd_reg_req_s;
endpackage

// *** hw/msd_seg_decode.sv ***
// Combinational segment hit logic for the 0C0000h to 0EFFFFh memory window.
`timescale 1ns/1ps
module msd_seg_decode (
  // Attribute bits and global enable
  input  wire logic [2*msd_pkg::SEG_COUNT-1:0] attr_in,
  input  wire logic                             global_en_in,
  // Current access
  input  wire msd_pkg::msd_access_s             access_in,
  // Result
  output logic                                  hit_out
);
  import msd_pkg::*;

  logic                 in_window;
  logic [SEG_IDX_W-1:0] idx;
  logic [SEG_COUNT-1:0] seg_hit;

  assign in_window = access_in.addr[31:20] == SEG_TOP_ZERO
                     && access_in.addr[19:18] == SEG_BAND
                     && access_in.addr[17:16] != SEG_EXCLUDED;
  assign idx = access_in.addr[17:14];

  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g++) begin : g_seg
      assign seg_hit[g] = in_window && idx == SEG_IDX_W'(g)
                          && attr_in[2*g + (access_in.write ? 1 : 0)];
    end
  endgenerate

  assign hit_out = global_en_in && access_in.valid && !access_in.io && |seg_hit;
endmodule

// *** hw/msd_com_decode.sv ***
// Combinational encoded select logic for the two serial ports.
`timescale 1ns/1ps
module msd_com_decode (
  // Port range fields
  input  wire msd_pkg::msd_com_sel_e   com_a_in,
  input  wire msd_pkg::msd_com_sel_e   com_b_in,
  // Current access
  input  wire msd_pkg::msd_access_s    access_in,
  // Result
  output logic [msd_pkg::ECS_W-1:0]    code_out
);
  import msd_pkg::*;

  logic io_ok;
  logic a_hit;
  logic b_hit;

  function automatic logic port_hit(input msd_com_sel_e sel, input logic [31:0] addr);
    logic r;
    r = 1'b0;
    unique case (sel)
      MSD_COM_PRIMARY: r = addr[15:3] == COM_PRIMARY_BASE;
      MSD_COM_SECONDARY: r = addr[15:3] == COM_SECONDARY_BASE;
      MSD_COM_RSVD,
      MSD_COM_OFF: r = 1'b0;
    endcase
    return r;
  endfunction

  assign io_ok = access_in.valid && access_in.io;
  assign a_hit = io_ok && port_hit(com_a_in, access_in.addr);
  assign b_hit = io_ok && port_hit(com_b_in, access_in.addr) && com_a_in != com_b_in;

  assign code_out = a_hit ? ECS_PORT_A : (b_hit ? ECS_PORT_B : ECS_IDLE);
endmodule

// *** hw/msd_decode_top.sv ***
// Register file and registered outputs of the memory select and serial decode block.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// - Serial A field picks 3F8h, 2F8h or off.
// - Hit in chosen range drives port A code.
// - Reset leaves serial A field disabled.
// - Same range on both ports mutes B.
// - Read enable set selects memory on reads.
// - Write enable set selects memory on writes.
// - Cleared enable bit blocks that direction.
// - Both clear or global off blocks segment.
// - First attribute register covers 0C segments.
// - Second attribute register covers 0D segments.
// - Third attribute register covers 0E segments.
// - Attribute registers reset zero, read back.
module msd_decode_top (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rstn_in,
  // Register port
  input  wire msd_pkg::msd_reg_req_s     reg_req_in,
  output logic [msd_pkg::REG_DW-1:0]     reg_rdata_out,
  // Access under decode
  input  wire msd_pkg::msd_access_s      access_in,
  // Decode results
  output logic                           main_memory_select_n_out,
  output logic [msd_pkg::ECS_W-1:0]      encoded_select_lines_out
);
  import msd_pkg::*;

  localparam logic [1:0] IDX_NONE = 2'h3;

  logic [REG_DW-1:0]              attr [ATTR_COUNT];
  logic [REG_DW-1:0]              next_attr [ATTR_COUNT];
  msd_com_sel_e                   com_a;
  msd_com_sel_e                   next_com_a;
  msd_com_sel_e                   com_b;
  msd_com_sel_e                   next_com_b;
  logic                           memsel_en;
  logic                           next_memsel_en;
  logic [REG_DW-1:0]              next_rdata;
  logic                           next_mem_sel_n;
  logic [ECS_W-1:0]               next_ecs;
  logic [2*SEG_COUNT-1:0]         attr_flat;
  logic                           mem_hit;
  logic [ECS_W-1:0]               com_code;

  // Maps a register offset onto an attribute register number.
  function automatic logic [1:0] attr_index(input logic [REG_AW-1:0] a);
    logic [1:0] r;
    r = IDX_NONE;
    if (a == ROM_C_ATTR_OFS) begin
      r = 2'h0;
    end else if (a == ROM_D_ATTR_OFS) begin
      r = 2'h1;
    end else if (a == BIOS_E_ATTR_OFS) begin
      r = 2'h2;
    end
    return r;
  endfunction

  assign attr_flat = {attr[2], attr[1], attr[0]};

  // Register writes.
  always_comb begin
    logic [1:0] wi;
    wi = attr_index(reg_req_in.addr);
    next_attr = attr;
    next_com_a = com_a;
    next_com_b = com_b;
    next_memsel_en = memsel_en;
    if (reg_req_in.wr) begin
      if (wi != IDX_NONE) begin
        next_attr[wi] = reg_req_in.wdata;
      end else if (reg_req_in.addr == SERIAL_CFG_OFS) begin
        next_com_a = msd_com_sel_e'(reg_req_in.wdata[COM_A_LSB +: 2]);
        next_com_b = msd_com_sel_e'(reg_req_in.wdata[COM_B_LSB +: 2]);
      end else if (reg_req_in.addr == MEMSEL_CTRL_OFS) begin
        next_memsel_en = reg_req_in.wdata[MEMSEL_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < ATTR_COUNT; i++) begin
        attr[i] <= ATTR_RESET;
      end
      com_a <= MSD_COM_OFF;
      com_b <= MSD_COM_OFF;
      memsel_en <= MEMSEL_EN_RESET;
    end else begin
      attr <= next_attr;
      com_a <= next_com_a;
      com_b <= next_com_b;
      memsel_en <= next_memsel_en;
    end
  end

  // Read data: valid only in the cycle after the strobe; unmapped reads give zero.
  always_comb begin
    logic [1:0] ri;
    ri = attr_index(reg_req_in.addr);
    next_rdata = '0;
    if (reg_req_in.rd) begin
      if (ri != IDX_NONE) begin
        next_rdata = attr[ri];
      end else if (reg_req_in.addr == SERIAL_CFG_OFS) begin
        next_rdata[COM_A_LSB +: 2] = com_a;
        next_rdata[COM_B_LSB +: 2] = com_b;
      end else if (reg_req_in.addr == MEMSEL_CTRL_OFS) begin
        next_rdata[MEMSEL_EN_BIT] = memsel_en;
      end
    end
  end

  msd_seg_decode u_seg (
    .attr_in      (attr_flat),
    .global_en_in (memsel_en),
    .access_in    (access_in),
    .hit_out      (mem_hit)
  );

  msd_com_decode u_com (
    .com_a_in  (com_a),
    .com_b_in  (com_b),
    .access_in (access_in),
    .code_out  (com_code)
  );

  // The decision itself is combinational; one flop stage keeps the pins glitch free,
  // at the cost of one cycle from address to select.
  // decode from live inputs.
  always_comb begin
    next_mem_sel_n = !mem_hit;
    next_ecs = com_code;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= '0;
      main_memory_select_n_out <= 1'b1;
      encoded_select_lines_out <= ECS_IDLE;
    end else begin
      reg_rdata_out <= next_rdata;
      main_memory_select_n_out <= next_mem_sel_n;
      encoded_select_lines_out <= next_ecs;
    end
  end

  // Helper logic for the checks below.
  logic                 chk_window;
  logic [SEG_IDX_W-1:0] chk_idx;
  logic                 chk_bit;
  logic                 chk_mem;
  logic                 chk_io;
  logic                 serial_written;
  logic                 attr_written;
  logic                 chk_attr_wr;
  logic                 chk_unmapped;

  assign chk_window = access_in.addr[31:20] == SEG_TOP_ZERO
                      && access_in.addr[19:18] == SEG_BAND
                      && access_in.addr[17:16] != SEG_EXCLUDED;
  assign chk_idx = access_in.addr[17:14];
  assign chk_bit = attr_flat[{chk_idx, access_in.write}];
  assign chk_mem = access_in.valid && !access_in.io && chk_window;
  assign chk_io = access_in.valid && access_in.io;
  // Register strobe decodes shared by the register checks.
  assign chk_attr_wr = reg_req_in.wr && attr_index(reg_req_in.addr) != IDX_NONE;
  assign chk_unmapped = attr_index(reg_req_in.addr) == IDX_NONE
                        && reg_req_in.addr != SERIAL_CFG_OFS
                        && reg_req_in.addr != MEMSEL_CTRL_OFS;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_written <= 1'b0;
      attr_written <= 1'b0;
    end else begin
      if (reg_req_in.wr && reg_req_in.addr == SERIAL_CFG_OFS) begin
        serial_written <= 1'b1;
      end
      if (reg_req_in.wr && attr_index(reg_req_in.addr) != IDX_NONE) begin
        attr_written <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  com_primary_a: assert property (
    chk_io && com_a == MSD_COM_PRIMARY && access_in.addr[15:3] == COM_PRIMARY_BASE
    |=> encoded_select_lines_out == ECS_PORT_A)
    else $error("port A missed in primary range");

  com_secondary_a: assert property (
    chk_io && com_a == MSD_COM_SECONDARY && access_in.addr[15:3] == COM_SECONDARY_BASE
    |=> encoded_select_lines_out == ECS_PORT_A)
    else $error("port A missed in secondary range");

  com_a_off_a: assert property (
    com_a == MSD_COM_OFF || com_a == MSD_COM_RSVD
    |=> encoded_select_lines_out != ECS_PORT_A)
    else $error("port A code while disabled");

  com_reset_a: assert property (
    !serial_written |-> com_a == MSD_COM_OFF ##1 encoded_select_lines_out != ECS_PORT_A)
    else $error("serial port A not disabled after reset");

  com_dup_a: assert property (
    com_a == com_b |=> encoded_select_lines_out != ECS_PORT_B)
    else $error("port B code with duplicate range");

  seg_read_a: assert property (
    chk_mem && !access_in.write && memsel_en && chk_bit
    |=> !main_memory_select_n_out)
    else $error("memory select missing on enabled read");

  seg_write_a: assert property (
    chk_mem && access_in.write && memsel_en && chk_bit
    |=> !main_memory_select_n_out)
    else $error("memory select missing on enabled write");

  seg_block_a: assert property (
    access_in.valid && (!chk_mem || !chk_bit || !memsel_en)
    |=> main_memory_select_n_out)
    else $error("memory select on blocked access");

  seg_idle_a: assert property (
    !access_in.valid |=> main_memory_select_n_out
    && encoded_select_lines_out == ECS_IDLE)
    else $error("decode output without access");

  attr_reset_a: assert property (
    !attr_written |-> attr_flat == '0 ##1 (!chk_mem || main_memory_select_n_out))
    else $error("attribute not zero before first write");

  attr_read_a: assert property (
    reg_req_in.rd && reg_req_in.addr == ROM_D_ATTR_OFS
    |=> reg_rdata_out == $past(attr[1]))
    else $error("attribute read data wrong");

  rdata_quiet_a: assert property (
    !reg_req_in.rd |=> reg_rdata_out == '0)
    else $error("read data outside read slot");

  // Port B checks keep port A off the address, so only B can answer.
  com_b_primary_a: assert property (
    chk_io && com_b == MSD_COM_PRIMARY && com_a != MSD_COM_PRIMARY
    && access_in.addr[15:3] == COM_PRIMARY_BASE
    |=> encoded_select_lines_out == ECS_PORT_B)
    else $error("port B missed in primary range");

  com_b_secondary_a: assert property (
    chk_io && com_b == MSD_COM_SECONDARY && com_a != MSD_COM_SECONDARY
    && access_in.addr[15:3] == COM_SECONDARY_BASE
    |=> encoded_select_lines_out == ECS_PORT_B)
    else $error("port B missed in secondary range");

  com_miss_a: assert property (
    chk_io && access_in.addr[15:3] != COM_PRIMARY_BASE
    && access_in.addr[15:3] != COM_SECONDARY_BASE
    |=> encoded_select_lines_out == ECS_IDLE)
    else $error("port code outside both ranges");

  com_mem_a: assert property (
    access_in.valid && !access_in.io |=> encoded_select_lines_out == ECS_IDLE)
    else $error("port code on memory access");

  com_b_off_a: assert property (
    com_b == MSD_COM_OFF || com_b == MSD_COM_RSVD
    |=> encoded_select_lines_out != ECS_PORT_B)
    else $error("port B code while disabled");

  memsel_off_a: assert property (
    !memsel_en |=> main_memory_select_n_out)
    else $error("memory select with global enable off");

  seg_pair_off_a: assert property (
    chk_mem && !attr_flat[{chk_idx, 1'b0}] && !attr_flat[{chk_idx, 1'b1}]
    |=> main_memory_select_n_out)
    else $error("memory select on closed segment");

  seg_outside_a: assert property (
    access_in.valid && !access_in.io && !chk_window |=> main_memory_select_n_out)
    else $error("memory select outside window");

  attr_write_c_a: assert property (
    reg_req_in.wr && reg_req_in.addr == ROM_C_ATTR_OFS
    |=> attr[0] == $past(reg_req_in.wdata))
    else $error("first attribute register write lost");

  attr_write_d_a: assert property (
    reg_req_in.wr && reg_req_in.addr == ROM_D_ATTR_OFS
    |=> attr[1] == $past(reg_req_in.wdata))
    else $error("second attribute register write lost");

  attr_write_e_a: assert property (
    reg_req_in.wr && reg_req_in.addr == BIOS_E_ATTR_OFS
    |=> attr[2] == $past(reg_req_in.wdata))
    else $error("third attribute register write lost");

  attr_keep_a: assert property (
    !chk_attr_wr |=> $stable(attr_flat))
    else $error("attribute changed without a write");

  serial_write_a: assert property (
    reg_req_in.wr && reg_req_in.addr == SERIAL_CFG_OFS
    |=> com_a == $past(reg_req_in.wdata[COM_A_LSB +: 2])
    && com_b == $past(reg_req_in.wdata[COM_B_LSB +: 2]))
    else $error("serial field write lost");

  memsel_write_a: assert property (
    reg_req_in.wr && reg_req_in.addr == MEMSEL_CTRL_OFS
    |=> memsel_en == $past(reg_req_in.wdata[MEMSEL_EN_BIT]))
    else $error("global enable write lost");

  attr_read_c_a: assert property (
    reg_req_in.rd && reg_req_in.addr == ROM_C_ATTR_OFS
    |=> reg_rdata_out == $past(attr[0]))
    else $error("first attribute read data wrong");

  attr_read_e_a: assert property (
    reg_req_in.rd && reg_req_in.addr == BIOS_E_ATTR_OFS
    |=> reg_rdata_out == $past(attr[2]))
    else $error("third attribute read data wrong");

  serial_read_a: assert property (
    reg_req_in.rd && reg_req_in.addr == SERIAL_CFG_OFS
    |=> reg_rdata_out[COM_A_LSB +: 2] == $past(com_a)
    && reg_rdata_out[COM_B_LSB +: 2] == $past(com_b))
    else $error("serial field read data wrong");

  unmapped_read_a: assert property (
    reg_req_in.rd && chk_unmapped |=> reg_rdata_out == '0)
    else $error("read data from unmapped offset");
endmodule

// *** tb/msd_far_model.sv ***
// Far side sink that counts the cycles in which main memory is selected.
`timescale 1ns/1ps
module msd_far_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Select from the decoder
  input  wire logic main_memory_select_n_in,
  // Cycles seen selected
  output int        select_count_out
);
  // claimed cycles.
  // The memory controller claims a cycle only while the active low select is low.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      select_count_out <= 0;
    end else if (main_memory_select_n_in == 1'b0) begin
      select_count_out <= select_count_out + 1;
    end
  end
endmodule

// *** tb/msd_decode_top_bench.sv ***
// Register and decode tests for the memory select and serial decode block.
`timescale 1ns/1ps
module msd_decode_top_bench;
  import msd_pkg::*;
  logic         clk_in;
  logic         rstn_in;
  msd_reg_req_s req;
  logic [7:0]   rdata;
  msd_access_s  acc;
  logic         sel_n;
  logic [2:0]   code;
  int           seen_sel;
  int           lows;
  int           failures;
  int           tests_run;
  logic [7:0]   d;
  logic [31:0]  a;

  msd_decode_top dut (
    .clk_in                   (clk_in),
    .rstn_in                  (rstn_in),
    .reg_req_in               (req),
    .reg_rdata_out            (rdata),
    .access_in                (acc),
    .main_memory_select_n_out (sel_n),
    .encoded_select_lines_out (code)
  );

  msd_far_model far (
    .clk_in                  (clk_in),
    .rstn_in                 (rstn_in),
    .main_memory_select_n_in (sel_n),
    .select_count_out        (seen_sel)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] ad, logic [7:0] wd);
    @(posedge clk_in);
    req <= '{1'b1, 1'b0, ad, wd};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(logic [7:0] ad, output logic [7:0] q);
    @(posedge clk_in);
    req <= '{1'b0, 1'b1, ad, 8'h00};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 q = rdata;
  endtask

  // One access cycle; outputs are looked at in the single cycle they answer it.
  task automatic go(logic io, logic w, logic [31:0] ad);
    @(posedge clk_in);
    acc <= '{1'b1, io, w, ad};
    @(posedge clk_in);
    acc.valid <= 1'b0;
    #1;
  endtask

  task automatic mem(logic w, logic [31:0] ad, logic e);
    go(1'b0, w, ad);
    if (e == 1'b0) lows++;
    check("mem_select_n", {7'h00, sel_n}, {7'h00, e});
    check("mem_code", {5'h00, code}, {5'h00, ECS_IDLE});
  endtask

  task automatic ser(logic [31:0] ad, logic [2:0] e);
    go(1'b1, 1'b0, ad);
    check("io_code", {5'h00, code}, {5'h00, e});
    check("io_select_n", {7'h00, sel_n}, 8'h01);
  endtask

  localparam logic [7:0]  CFG [10] = '{8'hFC, 8'hFC, 8'hFC, 8'h01, 8'h01, 8'hFE, 8'hFE, 8'h00,
                                       8'h04, 8'h09};
  localparam logic [31:0] ADR [10] = '{32'h3F8, 32'h3FF, 32'h400, 32'h2F8, 32'h3F8,
                                       32'h3F8, 32'h2F8, 32'h3F8, 32'h2F8, 32'h3F8};
  localparam logic [2:0]  EXP [10] = '{3'h2, 3'h2, 3'h7, 3'h2, 3'h3, 3'h7, 3'h7, 3'h2,
                                       3'h3, 3'h7};

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    test_done();
  end

  initial begin
    rstn_in = 1'b0;
    req = '0;
    acc = '0;
    lows = 0;
    failures = 0;
    tests_run = 0;
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      rd(ROM_C_ATTR_OFS + 8'(r), d);
      check("attr_reset", d, 8'h00);
    end
    rd(8'h57, d);
    check("unmapped", d, 8'h00);
    rd(SERIAL_CFG_OFS, d);
    check("serial_reset", d, 8'h0F);
    rd(MEMSEL_CTRL_OFS, d);
    check("memsel_reset", d, 8'h00);
    ser(32'h3F8, ECS_IDLE);
    // Third attribute register fully open but global enable still off.
    wr(BIOS_E_ATTR_OFS, 8'hFF);
    mem(1'b0, 32'h000E_0000, 1'b1);
    wr(MEMSEL_CTRL_OFS, 8'h10);
    rd(MEMSEL_CTRL_OFS, d);
    check("memsel_rb", d, 8'h10);
    mem(1'b0, 32'h000E_0000, 1'b0);
    mem(1'b0, 32'h000F_0000, 1'b1);
    mem(1'b0, 32'h000B_FFFF, 1'b1);
    go(1'b1, 1'b0, 32'h000E_0000);
    check("io_in_window", {7'h00, sel_n}, 8'h01);
    wr(BIOS_E_ATTR_OFS, 8'h00);
    mem(1'b1, 32'h000E_0000, 1'b1);
    // Each segment of each register, one enable bit at a time.
    for (int r = 0; r < 3; r++) begin
      for (int s = 0; s < 4; s++) begin
        a = 32'h000C_3FFF + 32'(r) * 32'h1_0000 + 32'(s) * 32'h4000;
        wr(ROM_C_ATTR_OFS + 8'(r), 8'h01 << (2 * s));
        rd(ROM_C_ATTR_OFS + 8'(r), d);
        check("attr_rb", d, 8'h01 << (2 * s));
        mem(1'b0, a, 1'b0);
        mem(1'b1, a, 1'b1);
        mem(1'b0, a ^ 32'h4000, 1'b1);
        wr(ROM_C_ATTR_OFS + 8'(r), 8'h02 << (2 * s));
        mem(1'b1, a, 1'b0);
        mem(1'b0, a, 1'b1);
      end
      wr(ROM_C_ATTR_OFS + 8'(r), 8'h00);
    end
    check("far_count", 8'(seen_sel), 8'(lows));
    for (int i = 0; i < 10; i++) begin
      wr(SERIAL_CFG_OFS, CFG[i]);
      rd(SERIAL_CFG_OFS, d);
      check("serial_rb", d, CFG[i] & 8'h0F);
      ser(ADR[i], EXP[i]);
    end
    mem(1'b0, 32'h3F8, 1'b1);
    // Open a segment so that the mid-run reset has something to close.
    wr(ROM_C_ATTR_OFS, 8'h55);
    mem(1'b0, 32'h000C_0000, 1'b0);
    // Second reset in mid-run after port A was opened.
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(ROM_C_ATTR_OFS, d);
    check("attr_rerst", d, 8'h00);
    rd(SERIAL_CFG_OFS, d);
    check("serial_rerst", d, 8'h0F);
    rd(MEMSEL_CTRL_OFS, d);
    check("memsel_rerst", d, 8'h00);
    mem(1'b0, 32'h000C_0000, 1'b1);
    ser(32'h3F8, ECS_IDLE);
    test_done();
  end
endmodule
